// File: include/cfw_consts.vh
`ifndef CFW_CONSTS_VH
`define CFW_CONSTS_VH

`define CFW_CMD_CFG_RD  4'ha
`define CFW_CMD_CFG_WR  4'hb
`define CFW_CMD_SPECIAL 4'h1
`define CFW_TYPE0       2'h0
`define CFW_TYPE1       2'h1
`define CFW_DEV_ALL1    5'h1f
`define CFW_FN_ALL1     3'h7
`define CFW_SPC_REG     6'h00
`define CFW_BUS_HI      23
`define CFW_BUS_LO      16
`define CFW_DEV_HI      15
`define CFW_DEV_LO      11
`define CFW_FN_HI       10
`define CFW_FN_LO       8
`define CFW_REG_HI      7
`define CFW_REG_LO      2
`define CFW_TYP_HI      1
`define CFW_TYP_LO      0
`define CFW_IDSEL_HI    31
`define CFW_IDSEL_LO    16
`define CFW_STEP_ZERO   3'h0
`define CFW_STEP_ONE    3'h1

`endif

// File: rtl/cfw_idsel.v
`timescale 1ns/1ps
`include "cfw_consts.vh"
module cfw_idsel (
  input  wire [4:0]  dev,
  output wire [15:0] idsel
);
  // Only 16 lines available; higher numbers need an external select
  assign idsel = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]);
endmodule

// File: rtl/cfw_decode.v
`timescale 1ns/1ps
`include "cfw_consts.vh"
module cfw_decode (
  input  wire [31:0] ad,
  input  wire [3:0]  cmd,
  input  wire        chip_sel,
  input  wire        from_primary,
  input  wire [7:0]  pri_bus,
  input  wire [7:0]  sec_bus,
  input  wire [7:0]  sub_bus,
  output wire        own_cfg,
  output wire        t1_to_t0,
  output wire        t1_down,
  output wire        t1_up,
  output wire        spc_gen,
  output wire        spc_ignore
);
  wire       is_cfg = (cmd == `CFW_CMD_CFG_RD) | (cmd == `CFW_CMD_CFG_WR);
  wire       is_wr  = (cmd == `CFW_CMD_CFG_WR);
  wire       type0  = (ad[`CFW_TYP_HI:`CFW_TYP_LO] == `CFW_TYPE0);
  wire       type1  = (ad[`CFW_TYP_HI:`CFW_TYP_LO] == `CFW_TYPE1);
  wire [7:0] bus    = ad[`CFW_BUS_HI:`CFW_BUS_LO];
  wire       all1   = (ad[`CFW_DEV_HI:`CFW_DEV_LO] == `CFW_DEV_ALL1) &
                      (ad[`CFW_FN_HI:`CFW_FN_LO] == `CFW_FN_ALL1);
  wire       in_rng = (bus >= sec_bus) & (bus <= sub_bus);

  assign own_cfg    = from_primary & is_cfg & type0 & chip_sel;
  assign spc_gen    = type1 & is_wr & all1 &
                      (ad[`CFW_REG_HI:`CFW_REG_LO] == `CFW_SPC_REG) &
                      (from_primary ? (bus == sec_bus) : (bus == pri_bus));
  assign t1_to_t0   = from_primary & is_cfg & type1 & (bus == sec_bus) &
                      ~spc_gen;
  assign t1_down    = from_primary & is_cfg & type1 & (bus > sec_bus) &
                      (bus <= sub_bus);
  assign t1_up      = ~from_primary & is_wr & type1 & ~in_rng & all1 & ~spc_gen;
  assign spc_ignore = (cmd == `CFW_CMD_SPECIAL);
endmodule

// File: rtl/cfw_top.v
`timescale 1ns/1ps
`include "cfw_consts.vh"
module cfw_top (
  input  wire        clk,
  input  wire        resetn,
  // Primary address phase
  input  wire        p_addr_phase,
  input  wire [31:0] p_ad,
  input  wire [3:0]  primary_cmd_byte_enables,
  input  wire        primary_config_chip_select,
  input  wire [3:0]  p_byte_en_n,
  input  wire [31:0] p_wdata,
  input  wire        p_more_phases,
  // Secondary address phase
  input  wire        s_addr_phase,
  input  wire [31:0] s_ad,
  input  wire [3:0]  s_cmd,
  input  wire [3:0]  s_byte_en_n,
  input  wire [31:0] s_wdata,
  input  wire        s_more_phases,
  // Configuration values
  input  wire [7:0]  pri_bus_num,
  input  wire [7:0]  sec_bus_num,
  input  wire [7:0]  sub_bus_num,
  input  wire [2:0]  addr_step_sel,
  input  wire [31:0] cfg_rdata,
  // Result of the forwarded cycle
  input  wire        fwd_done,
  input  wire        fwd_mabort,
  input  wire        fwd_tabort,
  input  wire [31:0] fwd_rdata,
  // Own configuration access
  output reg         cfg_acc_r,
  output reg         cfg_wr_r,
  output reg  [5:0]  cfg_reg_r,
  output reg  [3:0]  cfg_be_n_r,
  output reg  [31:0] cfg_wdata_r,
  // Primary target answer
  output reg         primary_device_select_n_r,
  output reg         p_trdy_r,
  output reg         p_stop_r,
  output reg  [31:0] p_rdata_r,
  output reg         p_rdata_oe_r,
  // Secondary target answer
  output reg         s_devsel_n_r,
  output reg         s_trdy_r,
  output reg         s_stop_r,
  output reg  [31:0] s_rdata_r,
  // Forwarded cycle
  output reg         fwd_down_r,
  output reg         fwd_addr_valid_r,
  output reg         fwd_frame_r,
  output reg  [31:0] fwd_addr_r,
  output reg  [3:0]  fwd_cmd_r,
  output reg  [3:0]  fwd_be_n_r,
  output reg  [31:0] fwd_data_r
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STEP = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DONE = 2'h3;

  // ----------------------------------------------------------------
  // Decode on both buses
  // ----------------------------------------------------------------
  wire p_own;
  wire p_t0;
  wire p_t1d;
  wire p_t1u;
  wire p_spc;
  wire p_ign;
  wire s_own;
  wire s_t0;
  wire s_t1d;
  wire s_t1u;
  wire s_spc;
  wire s_ign;

  cfw_decode u_dec_p (
    .ad           (p_ad),
    .cmd          (primary_cmd_byte_enables),
    .chip_sel     (primary_config_chip_select),
    .from_primary (1'b1),
    .pri_bus      (pri_bus_num),
    .sec_bus      (sec_bus_num),
    .sub_bus      (sub_bus_num),
    .own_cfg      (p_own),
    .t1_to_t0     (p_t0),
    .t1_down      (p_t1d),
    .t1_up        (p_t1u),
    .spc_gen      (p_spc),
    .spc_ignore   (p_ign)
  );

  // No chip select on the secondary side: own space unreachable there
  cfw_decode u_dec_s (
    .ad           (s_ad),
    .cmd          (s_cmd),
    .chip_sel     (1'b0),
    .from_primary (1'b0),
    .pri_bus      (pri_bus_num),
    .sec_bus      (sec_bus_num),
    .sub_bus      (sub_bus_num),
    .own_cfg      (s_own),
    .t1_to_t0     (s_t0),
    .t1_down      (s_t1d),
    .t1_up        (s_t1u),
    .spc_gen      (s_spc),
    .spc_ignore   (s_ign)
  );

  wire [15:0] idsel;

  cfw_idsel u_idsel (
    .dev   (p_ad[`CFW_DEV_HI:`CFW_DEV_LO]),
    .idsel (idsel)
  );

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  // Special cycle commands are masked out of every forwarding term
  wire p_fwd  = ~p_ign & (p_t0 | p_t1d | p_spc);
  wire s_fwd  = ~s_ign & (s_t1u | s_spc);
  wire p_go   = p_addr_phase & p_fwd;
  // One engine for both directions; primary wins a same-cycle clash
  wire s_go   = s_addr_phase & s_fwd & ~p_go;
  wire s_busy = s_addr_phase & s_fwd & p_go;
  wire go     = p_go | s_go;

  wire [31:0] g_ad   = p_go ? p_ad : s_ad;
  wire [3:0]  g_cmd  = p_go ? primary_cmd_byte_enables : s_cmd;
  wire        g_more = p_go ? p_more_phases : s_more_phases;
  wire        g_spc  = p_go ? p_spc : s_spc;

  // Translated Type-0 address: one-hot select for devices 0 to 15 (none above), zeroed device field
  wire [31:0] t0_addr = {idsel, 5'h00, p_ad[`CFW_FN_HI:`CFW_REG_LO], `CFW_TYPE0};
  wire [31:0] g_faddr = (p_go & p_t0) ? t0_addr : g_ad;
  wire [3:0]  g_fcmd  = g_spc ? `CFW_CMD_SPECIAL : g_cmd;

  reg  [1:0]  st_r;
  reg  [2:0]  step_r;
  reg         pend_dn_r;
  reg  [31:0] pend_ad_r;
  reg  [3:0]  pend_cmd_r;
  reg         pend_spc_r;
  reg         pend_fail_r;
  reg  [31:0] pend_rdata_r;
  reg         oc_r;
  reg         oc_more_r;

  // Repeat must carry the same address and command from the same side
  wire g_match = (st_r == ST_DONE) & (pend_dn_r == p_go) &
                 (pend_ad_r == g_ad) & (pend_cmd_r == g_cmd);

  // Answer: completion or target abort on a matching repeat, retry otherwise
  reg r_dev;
  reg r_trdy;
  reg r_stop;

  always @* begin
    r_dev  = 1'b1;
    r_trdy = 1'b0;
    r_stop = 1'b1;
    if (g_match) begin
      // Single transfer; disconnect when more phases asked for
      r_dev  = ~pend_fail_r;
      r_trdy = ~pend_fail_r;
      r_stop = pend_fail_r | g_more;
    end
  end

  // ----------------------------------------------------------------
  // Own configuration space and target answers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_acc_r                 <= 1'b0;
      cfg_wr_r                  <= 1'b0;
      cfg_reg_r                 <= 6'h00;
      cfg_be_n_r                <= 4'hf;
      cfg_wdata_r               <= 32'h00000000;
      oc_r                      <= 1'b0;
      oc_more_r                 <= 1'b0;
      primary_device_select_n_r <= 1'b1;
      p_trdy_r                  <= 1'b0;
      p_stop_r                  <= 1'b0;
      p_rdata_r                 <= 32'h00000000;
      p_rdata_oe_r              <= 1'b0;
      s_devsel_n_r              <= 1'b1;
      s_trdy_r                  <= 1'b0;
      s_stop_r                  <= 1'b0;
      s_rdata_r                 <= 32'h00000000;
    end else begin
      cfg_acc_r                 <= 1'b0;
      primary_device_select_n_r <= 1'b1;
      p_trdy_r                  <= 1'b0;
      p_stop_r                  <= 1'b0;
      p_rdata_oe_r              <= 1'b0;
      s_devsel_n_r              <= 1'b1;
      s_trdy_r                  <= 1'b0;
      s_stop_r                  <= 1'b0;
      oc_r                      <= p_addr_phase & p_own;
      // Own access bypasses the engine, whatever its state
      if (p_addr_phase & p_own) begin
        cfg_acc_r                 <= 1'b1;
        cfg_wr_r                  <= (primary_cmd_byte_enables == `CFW_CMD_CFG_WR);
        cfg_reg_r                 <= p_ad[`CFW_REG_HI:`CFW_REG_LO];
        cfg_be_n_r                <= p_byte_en_n;
        cfg_wdata_r               <= p_wdata;
        oc_more_r                 <= p_more_phases;
        primary_device_select_n_r <= 1'b0;
      end
      if (oc_r) begin
        primary_device_select_n_r <= 1'b0;
        p_trdy_r                  <= 1'b1;
        p_stop_r                  <= oc_more_r;
        p_rdata_r                 <= cfg_rdata;
        // Reads have no side effects, so byte enables are ignored
        p_rdata_oe_r              <= ~cfg_wr_r;
      end else if (p_go) begin
        primary_device_select_n_r <= ~r_dev;
        p_trdy_r                  <= r_trdy;
        p_stop_r                  <= r_stop;
        p_rdata_r                 <= pend_rdata_r;
        p_rdata_oe_r              <= r_trdy & (pend_cmd_r == `CFW_CMD_CFG_RD);
      end
      if (s_go) begin
        s_devsel_n_r <= ~r_dev;
        s_trdy_r     <= r_trdy;
        s_stop_r     <= r_stop;
        s_rdata_r    <= pend_rdata_r;
      end else if (s_busy) begin
        s_devsel_n_r <= 1'b0;
        s_stop_r     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Delayed transaction engine
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r             <= ST_IDLE;
      step_r           <= `CFW_STEP_ZERO;
      pend_dn_r        <= 1'b0;
      pend_ad_r        <= 32'h00000000;
      pend_cmd_r       <= 4'h0;
      pend_spc_r       <= 1'b0;
      pend_fail_r      <= 1'b0;
      pend_rdata_r     <= 32'h00000000;
      fwd_down_r       <= 1'b0;
      fwd_addr_valid_r <= 1'b0;
      fwd_frame_r      <= 1'b0;
      fwd_addr_r       <= 32'h00000000;
      fwd_cmd_r        <= 4'h0;
      fwd_be_n_r       <= 4'hf;
      fwd_data_r       <= 32'h00000000;
    end else begin
      fwd_frame_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r             <= ST_STEP;
            pend_dn_r        <= p_go;
            pend_ad_r        <= g_ad;
            pend_cmd_r       <= g_cmd;
            pend_spc_r       <= g_spc;
            pend_fail_r      <= 1'b0;
            fwd_down_r       <= p_go;
            fwd_addr_valid_r <= 1'b1;
            fwd_addr_r       <= g_faddr;
            fwd_cmd_r        <= g_fcmd;
            fwd_be_n_r       <= p_go ? p_byte_en_n : s_byte_en_n;
            fwd_data_r       <= p_go ? p_wdata : s_wdata;
            step_r           <= (p_go & p_t0) ? addr_step_sel : `CFW_STEP_ZERO;
          end
        end
        ST_STEP: begin
          // Address held steady before frame so select lines settle
          if (step_r == `CFW_STEP_ZERO) begin
            fwd_frame_r <= 1'b1;
            st_r        <= ST_WAIT;
          end else begin
            step_r <= step_r - `CFW_STEP_ONE;
          end
        end
        ST_WAIT: begin
          if (fwd_done) begin
            fwd_addr_valid_r <= 1'b0;
            pend_rdata_r     <= fwd_rdata;
            // Special cycles always master abort; that is not an error
            pend_fail_r      <= ~pend_spc_r & (fwd_mabort | fwd_tabort);
            st_r             <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (go & g_match) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: verif/cfw_chk_sva.sv
`timescale 1ns/1ps
module cfw_chk (
  input wire        clk,
  input wire        resetn,
  input wire        p_addr_phase,
  input wire [31:0] p_ad,
  input wire [3:0]  primary_cmd_byte_enables,
  input wire        primary_config_chip_select,
  input wire        p_more_phases,
  input wire        s_addr_phase,
  input wire [31:0] s_ad,
  input wire [3:0]  s_cmd,
  input wire [2:0]  addr_step_sel,
  input wire        cfg_acc_r,
  input wire        cfg_wr_r,
  input wire        primary_device_select_n_r,
  input wire        p_trdy_r,
  input wire        p_stop_r,
  input wire        p_rdata_oe_r,
  input wire        s_devsel_n_r,
  input wire        s_stop_r,
  input wire        fwd_down_r,
  input wire        fwd_addr_valid_r,
  input wire        fwd_frame_r,
  input wire [31:0] fwd_addr_r,
  input wire [3:0]  fwd_cmd_r
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire      p_cfg = primary_cmd_byte_enables[3:1] == 3'h5;
  wire      p_own = p_addr_phase && p_cfg && p_ad[1:0] == 2'h0 && primary_config_chip_select;
  reg [3:0] vcnt_r;
  // Cycles of valid address seen before the frame
  always @(posedge clk or negedge resetn) begin
    if (!resetn) vcnt_r <= 4'h0;
    else         vcnt_r <= fwd_addr_valid_r ? vcnt_r + 4'h1 : 4'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_own_claim: assert property (p_own |=> cfg_acc_r && !primary_device_select_n_r)
    else $error("own access not claimed");
  a_acc_cause: assert property (cfg_acc_r |-> $past(p_own))
    else $error("own access without cause");
  a_sec_type0: assert property (s_addr_phase && s_ad[1:0] == 2'h0 |=> s_devsel_n_r)
    else $error("secondary type0 claimed");
  a_own_disc: assert property (cfg_acc_r |=> p_trdy_r && !primary_device_select_n_r
    && p_stop_r == $past(p_more_phases, 2))
    else $error("own access data phase wrong");
  a_read_oe: assert property (cfg_acc_r && !cfg_wr_r |=> p_rdata_oe_r)
    else $error("own read not driving all bytes");
  a_type0_down: assert property (fwd_addr_valid_r && fwd_addr_r[1:0] == 2'h0 |-> fwd_down_r)
    else $error("type0 toward primary");
  a_idsel_hot: assert property (fwd_frame_r && fwd_addr_r[1:0] == 2'h0
    |-> $onehot0(fwd_addr_r[31:16]) && fwd_addr_r[15:11] == 5'h0)
    else $error("translated address bad");
  a_step_len: assert property (fwd_frame_r && fwd_addr_r[1:0] == 2'h0
    |-> vcnt_r == {1'b0, addr_step_sel} + 4'h1)
    else $error("address stepping length wrong");
  a_spc_ign_p: assert property (p_addr_phase && primary_cmd_byte_enables == 4'h1
    |=> primary_device_select_n_r && !p_stop_r)
    else $error("primary special cycle answered");
  a_spc_ign_s: assert property (s_addr_phase && s_cmd == 4'h1 |=> s_devsel_n_r && !s_stop_r)
    else $error("secondary special cycle answered");
  // One frame per captured request; a second frame would mean a second transfer
  a_frame_held: assert property (fwd_frame_r |-> fwd_addr_valid_r ##1 (!fwd_frame_r) [*3])
    else $error("frame without valid address or repeated");
endmodule

// File: verif/cfw_fwd_partner.sv
`timescale 1ns/1ps
module cfw_fwd_partner (
  input  wire        clk,
  input  wire        resetn,
  input  wire        fwd_frame_r,
  input  wire [31:0] fwd_addr_r,
  input  wire [3:0]  fwd_cmd_r,
  output reg         fwd_done,
  output reg         fwd_mabort,
  output reg         fwd_tabort,
  output reg  [31:0] fwd_rdata
);
  // ----------------------------------------
  // Target bus responder, random latency
  // ----------------------------------------
  initial begin
    fwd_done = 1'b0;
    fwd_mabort = 1'b0;
    fwd_tabort = 1'b0;
    fwd_rdata = 32'h0;
  end
  always @(posedge clk) begin
    if (resetn && fwd_frame_r) begin
      repeat (1 + $urandom % 4) @(posedge clk);
      fwd_done <= 1'b1;
      // Nobody answers a special cycle or an unselected type0
      fwd_mabort <= fwd_cmd_r == 4'h1 || (fwd_addr_r[1:0] == 2'h0 && fwd_addr_r[31:16] == 16'h0);
      // Register 63 stands for a target that aborts
      fwd_tabort <= fwd_cmd_r != 4'h1 && fwd_addr_r[7:2] == 6'h3f;
      fwd_rdata <= ~fwd_addr_r;
      @(posedge clk);
      fwd_done <= 1'b0;
      fwd_mabort <= 1'b0;
      fwd_tabort <= 1'b0;
    end
    // Stale data never looks valid
    fwd_rdata <= ~fwd_rdata;
  end
endmodule

// File: verif/test_cfw_top.sv
`timescale 1ns/1ps
`include "cfw_consts.vh"
`define CHK(a, b) begin total_checks = total_checks + 1; if ((a) !== (b)) begin \
  n_errors = n_errors + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_cfw_top;
  reg clk = 1'b0, resetn = 1'b0, p_addr_phase = 1'b0, primary_config_chip_select = 1'b0;
  reg p_more_phases = 1'b0, s_addr_phase = 1'b0, s_more_phases = 1'b0;
  reg [31:0] p_ad = 32'h0, p_wdata = 32'h0, s_ad = 32'h0, s_wdata = 32'h0, a;
  reg [3:0]  primary_cmd_byte_enables = 4'h0, p_byte_en_n = 4'hf, s_cmd = 4'h0, s_byte_en_n = 4'hf;
  reg [7:0]  pri_bus_num = 8'h01, sec_bus_num = 8'h02, sub_bus_num = 8'h05;
  reg [2:0]  addr_step_sel = 3'h0;
  wire [31:0] cfg_rdata, fwd_rdata, cfg_wdata_r, p_rdata_r, s_rdata_r, fwd_addr_r, fwd_data_r;
  wire [5:0]  cfg_reg_r;
  wire [3:0]  cfg_be_n_r, fwd_cmd_r, fwd_be_n_r;
  wire fwd_done, fwd_mabort, fwd_tabort, cfg_acc_r, cfg_wr_r, primary_device_select_n_r, p_trdy_r;
  wire p_stop_r, p_rdata_oe_r, s_devsel_n_r, s_trdy_r, s_stop_r, fwd_down_r, fwd_addr_valid_r;
  wire fwd_frame_r;
  integer n_errors = 0, total_checks = 0, i, d, seed;
  assign cfg_rdata = {26'h2c3a5f1, cfg_reg_r};
  always #20 clk = ~clk;
  cfw_top dut_u (.clk, .resetn, .p_addr_phase, .p_ad, .primary_cmd_byte_enables,
    .primary_config_chip_select, .p_byte_en_n, .p_wdata, .p_more_phases, .s_addr_phase, .s_ad,
    .s_cmd, .s_byte_en_n, .s_wdata, .s_more_phases, .pri_bus_num, .sec_bus_num, .sub_bus_num,
    .addr_step_sel, .cfg_rdata, .fwd_done, .fwd_mabort, .fwd_tabort, .fwd_rdata, .cfg_acc_r,
    .cfg_wr_r, .cfg_reg_r, .cfg_be_n_r, .cfg_wdata_r, .primary_device_select_n_r, .p_trdy_r,
    .p_stop_r, .p_rdata_r, .p_rdata_oe_r, .s_devsel_n_r, .s_trdy_r, .s_stop_r, .s_rdata_r,
    .fwd_down_r, .fwd_addr_valid_r, .fwd_frame_r, .fwd_addr_r, .fwd_cmd_r, .fwd_be_n_r,
    .fwd_data_r);
  cfw_fwd_partner far_u (.clk, .resetn, .fwd_frame_r, .fwd_addr_r, .fwd_cmd_r, .fwd_done,
    .fwd_mabort, .fwd_tabort, .fwd_rdata);
  // ----------------------------------------
  // Tasks and model
  // ----------------------------------------
  function [2:0] ans(input s);
    ans = s ? {s_devsel_n_r, s_trdy_r, s_stop_r} : {primary_device_select_n_r, p_trdy_r, p_stop_r};
  endfunction
  function [31:0] t0(input [31:0] x);
    t0 = (x[15] ? 32'h0 : 32'h1 << (16 + x[14:11])) | (x & 32'h7fc);
  endfunction
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task addr_ph(input s, input [31:0] ad, input [3:0] cmd, input more, input cs);
    begin
      @(posedge clk);
      if (s) begin
        s_addr_phase <= 1'b1; s_ad <= ad; s_cmd <= cmd; s_more_phases <= more;
        s_byte_en_n <= $urandom; s_wdata <= $urandom;
      end else begin
        p_addr_phase <= 1'b1; p_ad <= ad; primary_cmd_byte_enables <= cmd; p_more_phases <= more;
        p_byte_en_n <= $urandom; p_wdata <= $urandom; primary_config_chip_select <= cs;
      end
      @(posedge clk);
      p_addr_phase <= 1'b0;
      s_addr_phase <= 1'b0;
      #1;
    end
  endtask
  task own(input [5:0] rg, input wr, input more, input cs);
    begin
      a = $urandom;
      a[7:0] = {rg, 2'h0};
      addr_ph(1'b0, a, wr ? `CFW_CMD_CFG_WR : `CFW_CMD_CFG_RD, more, cs);
      `CHK(cfg_acc_r, cs)
      if (cs) `CHK({cfg_wr_r, cfg_reg_r, cfg_be_n_r}, {wr, rg, p_byte_en_n})
      if (cs && wr) `CHK(cfg_wdata_r, p_wdata)
      @(posedge clk); #1;
      `CHK(ans(1'b0), cs ? {2'b01, more} : 3'b100)
      if (cs && !wr) `CHK({p_rdata_oe_r, p_rdata_r}, {1'b1, 26'h2c3a5f1, rg})
    end
  endtask
  task ign(input s, input [31:0] ad, input [3:0] cmd);
    begin
      addr_ph(s, ad, cmd, 1'b1, 1'b1);
      `CHK({ans(s), fwd_addr_valid_r}, 4'h8)
    end
  endtask
  task fwd(input s, input [31:0] ad, input [3:0] cmd, input [31:0] ea, input [3:0] ec,
           input ed, input ab);
    reg more;
    begin
      more = $urandom;
      addr_ph(s, ad, cmd, more, 1'b0);
      `CHK(ans(s), 3'b001)
      `CHK({fwd_addr_valid_r, fwd_down_r, fwd_cmd_r}, {1'b1, ed, ec})
      `CHK(fwd_addr_r, ea)
      `CHK({fwd_be_n_r, fwd_data_r}, s ? {s_byte_en_n, s_wdata} : {p_byte_en_n, p_wdata})
      for (i = 0; i < 60 && fwd_addr_valid_r !== 1'b0; i = i + 1) begin
        @(posedge clk); #1;
      end
      if (i == 60) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t forward never finished", $time);
        end_sim;
      end
      addr_ph(s, ad, cmd, more, 1'b0);
      `CHK(ans(s), ab ? 3'b101 : {2'b01, more})
      if (!ab && !cmd[0]) `CHK(s ? s_rdata_r : p_rdata_r, ~ea)
      if (!s) `CHK(p_rdata_oe_r, !ab && !cmd[0])
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    seed = $urandom(97);
    for (d = 0; d < 10; d = d + 1) own($urandom, $urandom, $urandom, d % 4 != 3);
    $display("own config done");
    ign(1'b1, 32'h00000004, `CFW_CMD_CFG_RD);
    ign(1'b0, 32'h00020001, `CFW_CMD_SPECIAL);
    ign(1'b1, 32'h00010001, `CFW_CMD_SPECIAL);
    $display("ignore done");
    for (d = 0; d < 18; d = d + 1) begin
      @(posedge clk);
      addr_step_sel <= $urandom;
      a = $urandom;
      a[23:11] = {sec_bus_num, d[4:0]};
      a[1:0] = `CFW_TYPE1;
      fwd(1'b0, a, d[0] ? `CFW_CMD_CFG_WR : `CFW_CMD_CFG_RD, t0(a),
          d[0] ? `CFW_CMD_CFG_WR : `CFW_CMD_CFG_RD, 1'b1, d > 15 || a[7:2] == 6'h3f);
    end
    $display("translate done");
    a = 32'h0305a101;
    fwd(1'b0, a, `CFW_CMD_CFG_RD, a, `CFW_CMD_CFG_RD, 1'b1, 1'b0);
    a = 32'h05050001;
    fwd(1'b0, a, `CFW_CMD_CFG_WR, a, `CFW_CMD_CFG_WR, 1'b1, 1'b0);
    a = 32'h0304a1fd;
    fwd(1'b0, a, `CFW_CMD_CFG_RD, a, `CFW_CMD_CFG_RD, 1'b1, 1'b1);
    ign(1'b0, 32'h05060001, `CFW_CMD_CFG_RD);
    a = 32'h0707ff11;
    fwd(1'b1, a, `CFW_CMD_CFG_WR, a, `CFW_CMD_CFG_WR, 1'b0, 1'b0);
    ign(1'b1, 32'h0002ff11, `CFW_CMD_CFG_WR);
    a = 32'h0902ff01;
    fwd(1'b0, a, `CFW_CMD_CFG_WR, a, `CFW_CMD_SPECIAL, 1'b1, 1'b0);
    a = 32'h0401ff01;
    fwd(1'b1, a, `CFW_CMD_CFG_WR, a, `CFW_CMD_SPECIAL, 1'b0, 1'b0);
    $display("forward done");
    end_sim;
  end
endmodule
bind cfw_top cfw_chk chk_u (.clk, .resetn, .p_addr_phase, .p_ad, .primary_cmd_byte_enables,
  .primary_config_chip_select, .p_more_phases, .s_addr_phase, .s_ad, .s_cmd, .addr_step_sel,
  .cfg_acc_r, .cfg_wr_r, .primary_device_select_n_r, .p_trdy_r, .p_stop_r, .p_rdata_oe_r,
  .s_devsel_n_r, .s_stop_r, .fwd_down_r, .fwd_addr_valid_r, .fwd_frame_r, .fwd_addr_r,
  .fwd_cmd_r);
